// ---- verilog/hpdt_top.sv ----
module hpdt_top import hpdt_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic aclk, // System clock, 40 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic hot_plug_line_in, // Line level from pin
  output logic hot_plug_line_out, // Line level driven
  output logic hot_plug_line_oe, // High while driving the line
  output logic irq // Level interrupt
);
  localparam int QP_W = $clog2(QUEUE_DEPTH);

  // Bus state
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic aw_got_reg, w_got_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // Control and timing registers
  logic ctl_en_reg, ctl_cfg_reg, ctl_gen_reg, ctl_oval_reg;
  logic [7:0] short_pulse_min_time_reg, short_pulse_max_time_reg, pulse_generation_time_reg;
  logic [15:0] rise_detect_time_reg, fall_detect_time_reg;
  logic [2:0] sts_reg;
  logic [2:0] sts_next;
  logic [3:0] mask_reg;
  logic [1:0] q_reg [QUEUE_DEPTH];
  logic [QP_W-1:0] q_wptr_reg;

  // Line path and detector
  logic sync1_reg, sync2_reg;
  logic line_out_reg, line_oe_reg, irq_reg;
  hpdt_state_t state_reg, state_next;
  logic ev_rise, ev_unplug, ev_short, pulse_done;

  hpdt_meas_if meas ();

  hpdt_tick_timer #(.TICK_CYC(TICK_CYC)) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .m(meas)
  );

  // Write path decode
  wire aw_fire = s_axi_awvalid && awready_reg;
  wire w_fire = s_axi_wvalid && wready_reg;
  wire ar_fire = s_axi_arvalid && arready_reg;
  wire do_write = aw_got_reg && w_got_reg && !bvalid_reg;
  wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [31:0] wbits = wdata_reg & wmask;
  wire wr_ctl = do_write && waddr_reg == ADDR_LINE_CONTROL && wstrb_reg[0];
  wire wr_sts = do_write && waddr_reg == ADDR_EVENT_STATUS;
  wire wr_mask = do_write && waddr_reg == ADDR_EVENT_MASK;
  wire wr_queue = do_write && waddr_reg == ADDR_EVENT_QUEUE;
  wire wr_min = do_write && waddr_reg == ADDR_SHORT_MIN;
  wire wr_max = do_write && waddr_reg == ADDR_SHORT_MAX;
  wire wr_rise = do_write && waddr_reg == ADDR_RISE_DETECT;
  wire wr_fall = do_write && waddr_reg == ADDR_FALL_DETECT;
  wire wr_gen = do_write && waddr_reg == ADDR_PULSE_GEN;
  wire w_hit = wr_ctl || wr_sts || wr_mask || wr_queue || wr_min || wr_max || wr_rise
    || wr_fall || wr_gen || (do_write && waddr_reg == ADDR_LINE_CONTROL);

  // Mode, thresholds and visible values
  wire in_mode = ctl_en_reg && !ctl_cfg_reg;
  wire out_mode = ctl_en_reg && ctl_cfg_reg;
  wire line_s = sync2_reg;
  wire [TICKS_W-1:0] ticks = meas.ticks;
  wire [TICKS_W-1:0] thr_min = TICKS_W'(short_pulse_min_time_reg) + TICKS_W'(OFFSET_TICKS);
  wire [TICKS_W-1:0] thr_max = TICKS_W'(short_pulse_max_time_reg) + TICKS_W'(OFFSET_TICKS);
  wire [TICKS_W-1:0] thr_rise = TICKS_W'(rise_detect_time_reg) + TICKS_W'(OFFSET_TICKS);
  wire [TICKS_W-1:0] thr_fall = TICKS_W'(fall_detect_time_reg) + TICKS_W'(OFFSET_TICKS);
  wire [TICKS_W-1:0] thr_gen = TICKS_W'(pulse_generation_time_reg);
  wire [7:0] q_word = {q_reg[3], q_reg[2], q_reg[1], q_reg[0]};
  wire q_nempty = in_mode && (q_word != 8'h00);
  wire [3:0] ctl_word = {ctl_oval_reg && ctl_cfg_reg, ctl_gen_reg && ctl_cfg_reg,
    ctl_cfg_reg, ctl_en_reg};

  // Read path decode
  wire [31:0] rd_data =
    (s_axi_araddr == ADDR_LINE_CONTROL) ? {28'h0000000, ctl_word} :
    (s_axi_araddr == ADDR_EVENT_STATUS) ? {28'h0000000, q_nempty, sts_reg} :
    (s_axi_araddr == ADDR_EVENT_MASK) ? {28'h0000000, mask_reg} :
    (s_axi_araddr == ADDR_EVENT_QUEUE) ? {24'h000000, (in_mode ? q_word : 8'h00)} :
    (s_axi_araddr == ADDR_SHORT_MIN) ? {24'h000000, short_pulse_min_time_reg} :
    (s_axi_araddr == ADDR_SHORT_MAX) ? {24'h000000, short_pulse_max_time_reg} :
    (s_axi_araddr == ADDR_RISE_DETECT) ? {16'h0000, rise_detect_time_reg} :
    (s_axi_araddr == ADDR_FALL_DETECT) ? {16'h0000, fall_detect_time_reg} :
    (s_axi_araddr == ADDR_PULSE_GEN) ? {24'h000000, pulse_generation_time_reg} : 32'h00000000;
  wire r_hit = (s_axi_araddr == ADDR_LINE_CONTROL) || (s_axi_araddr == ADDR_EVENT_STATUS)
    || (s_axi_araddr == ADDR_EVENT_MASK) || (s_axi_araddr == ADDR_EVENT_QUEUE)
    || (s_axi_araddr == ADDR_SHORT_MIN) || (s_axi_araddr == ADDR_SHORT_MAX)
    || (s_axi_araddr == ADDR_RISE_DETECT) || (s_axi_araddr == ADDR_FALL_DETECT)
    || (s_axi_araddr == ADDR_PULSE_GEN);

  // Write address and data are held independently until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      awready_reg <= !aw_fire && !aw_got_reg && !bvalid_reg;
      wready_reg <= !w_fire && !w_got_reg && !bvalid_reg;
      if (aw_fire) begin
        aw_got_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_got_reg <= 1'b0;
      end
      if (w_fire) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_got_reg <= 1'b0;
      end
    end
  end

  // Write response; an unmapped address answers SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= w_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel: one read at a time, data captured at address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= !ar_fire && !rvalid_reg;
      if (ar_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_data;
        rresp_reg <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Control register; the request bit self-clears when the pulse ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_en_reg <= 1'b0;
      ctl_cfg_reg <= 1'b0;
      ctl_oval_reg <= 1'b0;
      ctl_gen_reg <= 1'b0;
    end else begin
      if (wr_ctl) begin
        ctl_en_reg <= wdata_reg[CTL_EN_BIT];
        ctl_cfg_reg <= wdata_reg[CTL_CFG_BIT];
        ctl_oval_reg <= wdata_reg[CTL_OVAL_BIT];
      end
      // A new request written with the completion wins over the clear
      if (wr_ctl && wdata_reg[CTL_GEN_BIT] && wdata_reg[CTL_CFG_BIT]) begin
        ctl_gen_reg <= 1'b1;
      end else if (pulse_done || !ctl_cfg_reg) begin
        ctl_gen_reg <= 1'b0;
      end
    end
  end

  // Timing registers take byte lanes; software must only touch them while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_pulse_min_time_reg <= RST_SHORT_MIN;
      short_pulse_max_time_reg <= RST_SHORT_MAX;
      rise_detect_time_reg <= RST_RISE_DETECT;
      fall_detect_time_reg <= RST_FALL_DETECT;
      pulse_generation_time_reg <= RST_PULSE_GEN;
      mask_reg <= RST_MASK;
    end else begin
      if (wr_min) short_pulse_min_time_reg <= (short_pulse_min_time_reg & ~wmask[7:0]) | wbits[7:0];
      if (wr_max) short_pulse_max_time_reg <= (short_pulse_max_time_reg & ~wmask[7:0]) | wbits[7:0];
      if (wr_rise) rise_detect_time_reg <= (rise_detect_time_reg & ~wmask[15:0]) | wbits[15:0];
      if (wr_fall) fall_detect_time_reg <= (fall_detect_time_reg & ~wmask[15:0]) | wbits[15:0];
      if (wr_gen) pulse_generation_time_reg <= (pulse_generation_time_reg & ~wmask[7:0]) | wbits[7:0];
      if (wr_mask) mask_reg <= (mask_reg & ~wmask[3:0]) | wbits[3:0];
    end
  end

  // Line synchroniser; only the second stage is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= hot_plug_line_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Period classifier; every state change restarts the tick count
  always_comb begin
    state_next = state_reg;
    ev_rise = 1'b0;
    ev_unplug = 1'b0;
    ev_short = 1'b0;
    pulse_done = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (out_mode && ctl_gen_reg) state_next = S_PULSE;
        else if (in_mode && line_s) state_next = S_HIGH_WAIT;
      end
      S_HIGH_WAIT: begin
        if (!in_mode || !line_s) begin
          state_next = S_IDLE;
        end else if (ticks >= thr_rise) begin
          ev_rise = 1'b1;
          state_next = S_PLUGGED;
        end
      end
      S_PLUGGED: begin
        if (!in_mode) state_next = S_IDLE;
        else if (!line_s) state_next = S_LOW_WAIT;
      end
      S_LOW_WAIT: begin
        if (!in_mode) begin
          state_next = S_IDLE;
        end else if (line_s) begin
          ev_short = (ticks >= thr_min) && (ticks < thr_max);
          state_next = S_PLUGGED;
        end else if (ticks >= thr_fall) begin
          ev_unplug = 1'b1;
          state_next = S_IDLE;
        end
      end
      S_PULSE: begin
        if (!out_mode) begin
          state_next = S_IDLE;
        end else if (ticks >= thr_gen) begin
          pulse_done = 1'b1;
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  assign meas.restart = (state_next != state_reg);

  // State and pin drive; the line is released to the output value after a pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      line_out_reg <= 1'b0;
      line_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      line_out_reg <= out_mode && ctl_oval_reg && (state_next != S_PULSE);
      line_oe_reg <= out_mode;
    end
  end

  // Sticky flags: set wins over a same-cycle write-one clear; cleared on disable
  wire [2:0] sts_set = {ev_rise, ev_unplug, ev_short || pulse_done};
  wire [2:0] sts_clr = wr_sts ? wbits[2:0] : 3'h0;
  always_comb begin
    sts_next = ctl_en_reg ? ((sts_reg & ~sts_clr) | sts_set) : 3'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      sts_reg <= sts_next;
      irq_reg <= |({q_nempty, sts_reg} & mask_reg);
    end
  end

  // Event queue: fills the next slot only if it is empty, else the event is dropped
  wire ev_any = ev_rise || ev_unplug || ev_short;
  wire [1:0] ev_code = ev_short ? EV_SHORT : (ev_unplug ? EV_UNPLUG : EV_RISE);
  wire q_push = ev_any && (q_reg[q_wptr_reg] == EV_EMPTY);

  for (genvar i = 0; i < QUEUE_DEPTH; i++) begin : g_slot
    wire clr_i = wr_queue && wstrb_reg[0] && (wdata_reg[2*i +: 2] == EV_RISE);
    always_ff @(posedge aclk) begin
      if (!aresetn || !in_mode) begin
        q_reg[i] <= EV_EMPTY;
      end else if (q_push && q_wptr_reg == QP_W'(i)) begin
        q_reg[i] <= ev_code;
      end else if (clr_i) begin
        q_reg[i] <= EV_EMPTY;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !in_mode) q_wptr_reg <= '0;
    else if (q_push) q_wptr_reg <= q_wptr_reg + QP_W'(1);
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign hot_plug_line_out = line_out_reg;
  assign hot_plug_line_oe = line_oe_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_pulse_start;
    state_reg == S_IDLE && state_next == S_PULSE;
  endsequence

  sequence seq_low_enter;
    state_reg == S_PLUGGED ##1 state_reg == S_LOW_WAIT;
  endsequence

  AST_SHORT_MIN: assert property (ev_short |-> ticks >= thr_min)
    else $error("Short pulse reported below minimum time");
  AST_SHORT_MAX: assert property (ev_short |-> ticks < thr_max)
    else $error("Short pulse reported beyond maximum time");
  AST_RISE_TIME: assert property (
    ev_rise |-> (state_reg == S_HIGH_WAIT && line_s && ticks >= thr_rise))
    else $error("Rising event before high-detect time");
  AST_UNPLUG_TIME: assert property (
    ev_unplug |-> (!line_s && ticks >= thr_fall && $past(state_reg) == S_LOW_WAIT))
    else $error("Unplug event before low-detect time");
  AST_LOW_RESTART: assert property (seq_low_enter |-> ticks == '0)
    else $error("Low period not measured from zero");
  AST_PULSE_LOW: assert property (
    (seq_pulse_start ##0 thr_gen != '0) |=> (!hot_plug_line_out && hot_plug_line_oe) [*2])
    else $error("Requested pulse did not drive the line low");
  AST_PULSE_LEN: assert property (pulse_done |-> ticks >= thr_gen)
    else $error("Pulse ended before programmed length");
  AST_PULSE_RETURN: assert property (
    (pulse_done && !wr_ctl) |=> hot_plug_line_out == ctl_oval_reg)
    else $error("Line not returned to output value after pulse");
  AST_FLAG_SET: assert property (
    ((ev_short || pulse_done) && !wr_ctl) |=> sts_reg[ST_SHORT_BIT])
    else $error("Short-pulse flag not set");
  AST_QUEUE_CODE: assert property (
    (q_push && !wr_ctl) |=> q_reg[$past(q_wptr_reg)] == $past(ev_code))
    else $error("Queue slot does not hold the event code");
endmodule

// ---- verilog/hpdt_pkg.sv ----
package hpdt_pkg;
  // Clock and timebase
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS = 50000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int FIXED_OFFSET_NS = 100000;
  localparam int OFFSET_TICKS = FIXED_OFFSET_NS / TICK_TIME_NS;
  localparam int TICKS_W = 17;

  // Register indices; byte address is four times the index
  localparam int ADDR_W = 14;
  localparam logic [11:0] IDX_LINE_CONTROL = 12'hC00;
  localparam logic [11:0] IDX_EVENT_STATUS = 12'hC01;
  localparam logic [11:0] IDX_EVENT_MASK = 12'hC02;
  localparam logic [11:0] IDX_EVENT_QUEUE = 12'hC03;
  localparam logic [11:0] IDX_SHORT_MIN = 12'hC04;
  localparam logic [11:0] IDX_SHORT_MAX = 12'hC05;
  localparam logic [11:0] IDX_RISE_DETECT = 12'hC06;
  localparam logic [11:0] IDX_FALL_DETECT = 12'hC08;
  localparam logic [11:0] IDX_PULSE_GEN = 12'hC0A;
  localparam logic [ADDR_W-1:0] ADDR_LINE_CONTROL = {IDX_LINE_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = {IDX_EVENT_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK = {IDX_EVENT_MASK, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVENT_QUEUE = {IDX_EVENT_QUEUE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SHORT_MIN = {IDX_SHORT_MIN, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SHORT_MAX = {IDX_SHORT_MAX, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RISE_DETECT = {IDX_RISE_DETECT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_FALL_DETECT = {IDX_FALL_DETECT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PULSE_GEN = {IDX_PULSE_GEN, 2'h0};

  // Field positions
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_CFG_BIT = 1;
  localparam int CTL_GEN_BIT = 2;
  localparam int CTL_OVAL_BIT = 3;
  localparam int ST_SHORT_BIT = 0;
  localparam int ST_UNPLUG_BIT = 1;
  localparam int ST_RISE_BIT = 2;
  localparam int ST_NEMPTY_BIT = 3;
  localparam int QUEUE_DEPTH = 4;

  // Reset values
  localparam logic [7:0] RST_SHORT_MIN = 8'h00;
  localparam logic [7:0] RST_SHORT_MAX = 8'h00;
  localparam logic [15:0] RST_RISE_DETECT = 16'h0000;
  localparam logic [15:0] RST_FALL_DETECT = 16'h0000;
  localparam logic [7:0] RST_PULSE_GEN = 8'h00;
  localparam logic [3:0] RST_MASK = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EV_EMPTY = 2'h0,
    EV_RISE = 2'h1,
    EV_UNPLUG = 2'h2,
    EV_SHORT = 2'h3
  } hpdt_event_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_HIGH_WAIT = 5'h02,
    S_PLUGGED = 5'h04,
    S_LOW_WAIT = 5'h08,
    S_PULSE = 5'h10
  } hpdt_state_t;
endpackage

// ---- verilog/hpdt_meas_if.sv ----
interface hpdt_meas_if;
  import hpdt_pkg::*;
  logic restart;
  logic [TICKS_W-1:0] ticks;
  modport owner (output restart, input ticks);
  modport timer (input restart, output ticks);
endinterface

// ---- verilog/hpdt_tick_timer.sv ----
module hpdt_tick_timer import hpdt_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  hpdt_meas_if.timer m // Restart in, elapsed ticks out
);
  localparam int PRE_W = $clog2(TICK_CYC + 1);
  localparam logic [TICKS_W-1:0] TICKS_MAX = {TICKS_W{1'b1}};

  logic [PRE_W-1:0] pre_reg;
  logic [TICKS_W-1:0] ticks_reg;

  wire wrap = (pre_reg == PRE_W'(TICK_CYC - 1));

  // Prescaler restarts with the count so every period is measured from zero
  always_ff @(posedge aclk) begin
    if (!aresetn || m.restart) begin
      pre_reg <= '0;
      ticks_reg <= '0;
    end else if (wrap) begin
      pre_reg <= '0;
      if (ticks_reg != TICKS_MAX) begin // Saturate rather than wrap to a short period
        ticks_reg <= ticks_reg + TICKS_W'(1);
      end
    end else begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  assign m.ticks = ticks_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TICK_STEP: assert property (
    (!m.restart && wrap && ticks_reg != TICKS_MAX) |=> ticks_reg == $past(ticks_reg) + 17'h1)
    else $error("Tick count did not advance at prescaler wrap");
  AST_TICK_RESTART: assert property (
    m.restart |=> (ticks_reg == '0 && pre_reg == '0))
    else $error("Restart did not clear the period count");
endmodule

// ---- testbench/hpdt_line_model.sv ----
module hpdt_line_model (
  input wire logic aclk, // System clock
  input wire logic dut_out, // Level the block drives
  input wire logic dut_oe, // High while the block drives
  input wire logic src_level, // Level the far end drives
  output logic line, // Resolved line level
  output int low_cycles // Length of the last driven low pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int run;
  // Far end lets go while the block drives, so the block's level wins
  assign line = dut_oe ? dut_out : src_level;
  // Measure each low pulse the block drives; an unknown level never counts
  always @(posedge aclk) begin
    if (dut_oe === 1'b1 && dut_out === 1'b0) begin
      run <= run + 1;
    end else begin
      if (run != 0) low_cycles <= run;
      run <= 0;
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
module tb_top import hpdt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 4;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, src_level;
  logic hot_plug_line, hot_plug_line_out, hot_plug_line_oe, irq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int n_mismatch, comparisons, low_cycles, i;
  hpdt_top #(.TICK_CYC(TC)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .hot_plug_line_in(hot_plug_line),
    .hot_plug_line_out(hot_plug_line_out), .hot_plug_line_oe(hot_plug_line_oe), .irq(irq));
  hpdt_line_model far_u (.aclk(aclk), .dut_out(hot_plug_line_out), .dut_oe(hot_plug_line_oe),
    .src_level(src_level), .line(hot_plug_line), .low_cycles(low_cycles));
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_ok, w_ok, b_ok;
    int n;
    aw_ok = 0;
    w_ok = 0;
    b_ok = 0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_ok && n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1 && !aw_ok) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_ok) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        b_ok = 1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    chk("write answer", 1, b_ok);
  endtask
  // Read: rready held until the answer is sampled
  task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    bit r_ok;
    int n;
    r_ok = 0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_ok && n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        r_ok = 1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    chk("read answer", 1, r_ok);
  endtask
  // Far end holds the line at a level for a number of cycles
  task automatic hold(input logic lv, input int cyc);
    @(posedge aclk);
    src_level <= lv;
    repeat (cyc - 1) @(posedge aclk);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Whole run needs well under a thousand cycles; this only catches a hang
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, src_level} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(ADDR_SHORT_MIN, rd, rs);
    chk("min reset", {24'h0, RST_SHORT_MIN}, rd);
    axr(ADDR_RISE_DETECT, rd, rs);
    chk("rise reset", {16'h0, RST_RISE_DETECT}, rd);
    axr(14'h3040, rd, rs);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    chk("unmapped data", 32'h0, rd);
    axw(14'h3040, 32'h1, rs);
    chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    // Thresholds while disabled: short window 3 to below 5 ticks, rise 5, fall 8
    axw(ADDR_SHORT_MIN, 32'h1, rs);
    axw(ADDR_SHORT_MAX, 32'h3, rs);
    axw(ADDR_RISE_DETECT, 32'h3, rs);
    axw(ADDR_FALL_DETECT, 32'h6, rs);
    axw(ADDR_PULSE_GEN, 32'h5, rs);
    axw(ADDR_EVENT_MASK, 32'h4, rs);
    chk("mask write resp", {30'h0, RESP_OKAY}, {30'h0, rs});
    axr(ADDR_FALL_DETECT, rd, rs);
    chk("fall readback", 32'h6, rd);
    chk("fall read resp", {30'h0, RESP_OKAY}, {30'h0, rs});
    axw(ADDR_LINE_CONTROL, 32'h1, rs);
    hold(1'b1, 10);
    axr(ADDR_EVENT_STATUS, rd, rs);
    chk("status early rise", 32'h0, rd);
    hold(1'b1, 30);
    axr(ADDR_EVENT_STATUS, rd, rs);
    chk("status rise", 32'hC, rd);
    chk("irq rise", 1, irq);
    hold(1'b0, 4);
    hold(1'b1, 30);
    hold(1'b0, 16);
    hold(1'b1, 30);
    hold(1'b0, 26);
    hold(1'b1, 30);
    axr(ADDR_EVENT_STATUS, rd, rs);
    chk("status short", 32'hD, rd);
    axr(ADDR_EVENT_QUEUE, rd, rs);
    chk("queue short", 32'h0D, rd);
    hold(1'b0, 50);
    axr(ADDR_EVENT_STATUS, rd, rs);
    chk("status unplug", 32'hF, rd);
    axr(ADDR_EVENT_QUEUE, rd, rs);
    chk("queue unplug", 32'h2D, rd);
    axw(ADDR_EVENT_MASK, 32'h0, rs);
    axr(ADDR_EVENT_MASK, rd, rs);
    chk("mask readback", 32'h0, rd);
    chk("irq masked", 0, irq);
    axw(ADDR_EVENT_STATUS, 32'h7, rs);
    axr(ADDR_EVENT_STATUS, rd, rs);
    chk("status cleared", 32'h8, rd);
    axw(ADDR_EVENT_QUEUE, 32'h15, rs);
    axr(ADDR_EVENT_QUEUE, rd, rs);
    chk("queue cleared", 32'h0, rd);
    // Output mode: output value set high before the pulse request
    axw(ADDR_LINE_CONTROL, 32'h0, rs);
    axw(ADDR_LINE_CONTROL, 32'hB, rs);
    axw(ADDR_LINE_CONTROL, 32'hF, rs);
    rd = 32'h0;
    i = 0;
    while (rd[0] !== 1'b1 && i < 20) begin
      axr(ADDR_EVENT_STATUS, rd, rs);
      i++;
    end
    chk("pulse done flag", 1, rd[0]);
    chk("pulse length", 1, low_cycles >= 5 * TC && low_cycles <= 5 * TC + 1);
    chk("line after pulse", 1, hot_plug_line);
    chk("line driven", 1, hot_plug_line_oe);
    axr(ADDR_LINE_CONTROL, rd, rs);
    chk("request self clear", 32'hB, rd);
    print_verdict;
  end
endmodule
